/* File: wkt_defines.vh */
// register map, field positions and reset values of the wake-up timer
`ifndef WKT_DEFINES_VH
`define WKT_DEFINES_VH

`define WKT_ADDR_RELOAD     32'hffff0340
`define WKT_ADDR_COUNT      32'hffff0344
`define WKT_ADDR_CONTROL    32'hffff0348
`define WKT_ADDR_ICLEAR     32'hffff034c
`define WKT_ADDR_ISTATUS    32'hffff0350
`define WKT_ADDR_IMASK      32'hffff0354

`define WKT_RST_RELOAD      32'h00000000
`define WKT_RST_COUNT       32'hffffffff
`define WKT_RST_CONTROL     16'h0000
`define WKT_CTRL_MASK       16'h07ff

`define WKT_F_PSC_LO        0
`define WKT_F_PSC_HI        3
`define WKT_F_FMT_LO        4
`define WKT_F_FMT_HI        5
`define WKT_F_PERIODIC      6
`define WKT_F_ENABLE        7
`define WKT_F_UP            8
`define WKT_F_SRC_LO        9
`define WKT_F_SRC_HI        10

`define WKT_SRC_CORE        2'h0
`define WKT_SRC_LPOSC       2'h1
`define WKT_SRC_XTAL        2'h2
`define WKT_SRC_PREC        2'h3

`define WKT_FMT_BIN         2'h0
`define WKT_FMT_RSVD        2'h1
`define WKT_FMT_HMS23       2'h2
`define WKT_FMT_HMS255      2'h3

`define WKT_HUND_MAX        8'h63
`define WKT_SECMIN_MAX      8'h3b
`define WKT_HOUR23_MAX      8'h17
`define WKT_HOUR255_MAX     8'hff

`endif

/* File: wkt_timer.v */
// wake-up timer: 32-bit up/down counter with prescaler and APB registers
//
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps
//
// Function
// R1 - 32-bit up/down counter behind a prescaler
// R2 - bits 10:9 choose core or 32k source
// R3 - bits 3:0 divide source by power of two
// R4 - keeps counting from 32k while core off
// R5 - overflow loads counter from reload register
// R6 - bit 8 set counts up, else down
// R7 - bit 7 enables counting, cleared halts
// R8 - bit 6 periodic, cleared free running
// R9 - bits 5:4 binary or time-of-day formats
// R10 - software uses time formats with 32k only
// R11 - software sets divide-by-256 for time formats
// R12 - any write to clear register drops interrupt
// R13 - count register read-only, resets all ones
// R14 - reload register read/write, resets to zero
// R15 - control 16 bits, resets zero, 15:11 reserved
// R16 - free wraps full range; periodic reloads
// R17 - terminal count sets flag until cleared

`include "wkt_defines.vh"

module wkt_timer #(
    parameter PSC_WIDTH = 15
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        core_clk_run,
    input  wire        lposc_clk,
    input  wire        xtal_clk,
    input  wire        prec_clk,
    output reg         irq
);

    // ************************************************************
    // registers and bus decode
    // ************************************************************
    reg  [31:0] reload_value;
    reg  [31:0] current_count;
    reg  [15:0] timer_control;
    reg         irq_status;
    reg         irq_mask;

    wire        acc_fire = psel & penable & pready;
    wire        wr_fire  = acc_fire & pwrite;
    reg         sel_reload;
    reg         sel_count;
    reg         sel_control;
    reg         sel_iclear;
    reg         sel_istatus;
    reg         sel_imask;
    reg         mapped;

    // full 32-bit compare: neighbouring blocks in the map must never alias here
    always @* begin
        sel_reload  = 1'b0;
        sel_count   = 1'b0;
        sel_control = 1'b0;
        sel_iclear  = 1'b0;
        sel_istatus = 1'b0;
        sel_imask   = 1'b0;
        if (paddr == `WKT_ADDR_RELOAD) begin
            sel_reload = 1'b1;
        end else if (paddr == `WKT_ADDR_COUNT) begin
            sel_count = 1'b1;
        end else if (paddr == `WKT_ADDR_CONTROL) begin
            sel_control = 1'b1;
        end else if (paddr == `WKT_ADDR_ICLEAR) begin
            sel_iclear = 1'b1;
        end else if (paddr == `WKT_ADDR_ISTATUS) begin
            sel_istatus = 1'b1;
        end else if (paddr == `WKT_ADDR_IMASK) begin
            sel_imask = 1'b1;
        end
        mapped = sel_reload | sel_count | sel_control |
                 sel_iclear | sel_istatus | sel_imask;
    end

    wire [3:0]  psc_code = timer_control[`WKT_F_PSC_HI:`WKT_F_PSC_LO];
    wire [1:0]  fmt      = timer_control[`WKT_F_FMT_HI:`WKT_F_FMT_LO];
    wire        periodic = timer_control[`WKT_F_PERIODIC];
    wire        enable   = timer_control[`WKT_F_ENABLE];
    wire        count_up = timer_control[`WKT_F_UP];
    wire [1:0]  src_sel  = timer_control[`WKT_F_SRC_HI:`WKT_F_SRC_LO];

    // ************************************************************
    // clock source selection
    // ************************************************************
    // the 32k inputs are sampled on pclk; a rising edge is one tick.
    // the core source only ticks while the core clock runs, the 32k
    // sources tick regardless, so the timer survives core shutdown.
    localparam N_SLOW = 3;

    wire [N_SLOW-1:0] slow_clk = {prec_clk, xtal_clk, lposc_clk};
    reg  [N_SLOW-1:0] slow_d;
    wire [N_SLOW-1:0] slow_rise;
    reg               src_tick;

    genvar            gi;

    generate
        for (gi = 0; gi < N_SLOW; gi = gi + 1) begin : g_slow
            // every source keeps its own history, so switching source
            // never sees a stale level from another input
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    slow_d[gi] <= 1'b0;
                end else begin
                    slow_d[gi] <= slow_clk[gi];
                end
            end

            assign slow_rise[gi] = slow_clk[gi] & ~slow_d[gi];
        end
    endgenerate

    always @* begin
        case (src_sel) // see R2
            `WKT_SRC_CORE:  src_tick = core_clk_run; // see R4
            `WKT_SRC_LPOSC: src_tick = slow_rise[0];
            `WKT_SRC_XTAL:  src_tick = slow_rise[1];
            default:        src_tick = slow_rise[2];
        endcase
    end

    // ************************************************************
    // prescaler
    // ************************************************************
    // codes 0, 4, 8 and 15 give 1, 16, 256 and 32768; every code n
    // divides by two to the n, which covers the undefined codes too.
    reg  [PSC_WIDTH-1:0] psc_cnt;
    wire [PSC_WIDTH:0]   psc_mask_w = ({{PSC_WIDTH{1'b0}}, 1'b1} << psc_code) - 1'b1;
    wire [PSC_WIDTH-1:0] psc_mask = psc_mask_w[PSC_WIDTH-1:0];
    wire                 count_tick = src_tick & ((psc_cnt & psc_mask) == psc_mask); // see R3

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psc_cnt <= {PSC_WIDTH{1'b0}};
        end else if (!enable) begin
            psc_cnt <= {PSC_WIDTH{1'b0}};
        end else if (src_tick) begin
            psc_cnt <= psc_cnt + 1'b1;
        end
    end

    // ************************************************************
    // next count value
    // ************************************************************
    wire        hms = (fmt == `WKT_FMT_HMS23) | (fmt == `WKT_FMT_HMS255); // see R9
    wire [7:0]  hour_max = (fmt == `WKT_FMT_HMS23) ? `WKT_HOUR23_MAX : `WKT_HOUR255_MAX;
    wire [7:0]  c_hr = current_count[31:24];
    wire [7:0]  c_mn = current_count[23:16];
    wire [7:0]  c_sc = current_count[15:8];
    wire [7:0]  c_hu = current_count[7:0];
    wire [31:0] hms_top = {hour_max, `WKT_SECMIN_MAX, `WKT_SECMIN_MAX, `WKT_HUND_MAX};

    reg  [31:0] stepped;
    reg         terminal;
    reg  [7:0]  n_hr;
    reg  [7:0]  n_mn;
    reg  [7:0]  n_sc;
    reg  [7:0]  n_hu;

    always @* begin
        n_hr = c_hr;
        n_mn = c_mn;
        n_sc = c_sc;
        n_hu = c_hu;
        if (!hms) begin
            // binary; the reserved format counts as binary
            terminal = count_up ? (current_count == 32'hffffffff)
                                : (current_count == 32'h00000000);
            stepped = count_up ? current_count + 32'h00000001
                               : current_count - 32'h00000001; // see R1 R6
        end else if (count_up) begin
            terminal = (current_count >= hms_top) |
                       (c_hr >= hour_max && c_mn >= `WKT_SECMIN_MAX &&
                        c_sc >= `WKT_SECMIN_MAX && c_hu >= `WKT_HUND_MAX);
            if (c_hu < `WKT_HUND_MAX) begin
                n_hu = c_hu + 8'h01;
            end else begin
                n_hu = 8'h00;
                if (c_sc < `WKT_SECMIN_MAX) begin
                    n_sc = c_sc + 8'h01;
                end else begin
                    n_sc = 8'h00;
                    if (c_mn < `WKT_SECMIN_MAX) begin
                        n_mn = c_mn + 8'h01;
                    end else begin
                        n_mn = 8'h00;
                        n_hr = (c_hr < hour_max) ? c_hr + 8'h01 : 8'h00;
                    end
                end
            end
            stepped = terminal ? 32'h00000000 : {n_hr, n_mn, n_sc, n_hu};
        end else begin
            terminal = (current_count == 32'h00000000);
            if (c_hu != 8'h00) begin
                n_hu = c_hu - 8'h01;
            end else begin
                n_hu = `WKT_HUND_MAX;
                if (c_sc != 8'h00) begin
                    n_sc = c_sc - 8'h01;
                end else begin
                    n_sc = `WKT_SECMIN_MAX;
                    if (c_mn != 8'h00) begin
                        n_mn = c_mn - 8'h01;
                    end else begin
                        n_mn = `WKT_SECMIN_MAX;
                        n_hr = c_hr - 8'h01;
                    end
                end
            end
            stepped = terminal ? hms_top : {n_hr, n_mn, n_sc, n_hu};
        end
    end

    // ************************************************************
    // counter
    // ************************************************************
    wire        tc_event = enable & count_tick & terminal;
    reg  [31:0] next_count;

    // a reload write outranks a tick in the same cycle, so software
    // always sees the value it wrote as the new starting point
    always @* begin
        next_count = current_count;
        if (wr_fire && sel_reload) begin
            next_count = pwdata;
        end else if (enable && count_tick) begin // see R7
            if (terminal && periodic) begin
                next_count = reload_value; // see R5 R8 R16
            end else begin
                next_count = stepped; // see R16
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            current_count <= `WKT_RST_COUNT; // see R13
        end else begin
            current_count <= next_count;
        end
    end

    // ************************************************************
    // software registers
    // ************************************************************
    reg  [31:0] next_reload;
    reg  [15:0] next_control;
    reg         next_mask;

    always @* begin
        next_reload  = reload_value;
        next_control = timer_control;
        next_mask    = irq_mask;
        if (wr_fire) begin
            if (sel_reload) begin
                next_reload = pwdata;
            end else if (sel_control) begin
                next_control = pwdata[15:0] & `WKT_CTRL_MASK; // see R15
            end else if (sel_imask) begin
                next_mask = pwdata[0];
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_value  <= `WKT_RST_RELOAD; // see R14
            timer_control <= `WKT_RST_CONTROL; // see R15
            irq_mask      <= 1'b0;
        end else begin
            reload_value  <= next_reload;
            timer_control <= next_control;
            irq_mask      <= next_mask;
        end
    end

    // a terminal count in the same cycle as a clear keeps the flag:
    // losing a wake-up event is worse than one extra interrupt
    wire        clr_req = wr_fire & (sel_iclear | (sel_istatus & pwdata[0])); // see R12
    reg         next_irq_status;
    reg         next_irq;

    always @* begin
        next_irq_status = irq_status;
        if (clr_req) begin
            next_irq_status = 1'b0;
        end
        if (tc_event) begin
            next_irq_status = 1'b1; // see R17
        end
        next_irq = irq_status & irq_mask;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= 1'b0;
            irq        <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq        <= next_irq;
        end
    end

    // ************************************************************
    // apb answer
    // ************************************************************
    // one wait state: pready rises the cycle after the access phase
    // starts, which lets read data come straight from a flip-flop.
    // the count is captured one cycle before it is shown, so a tick in
    // the answer cycle itself is not part of the returned value
    reg  [31:0] next_prdata;
    wire        answer = psel & penable & ~pready;

    always @* begin
        next_prdata = 32'h00000000;
        if (pwrite) begin
            next_prdata = 32'h00000000;
        end else if (sel_reload) begin
            next_prdata = reload_value;
        end else if (sel_count) begin
            next_prdata = current_count; // see R13
        end else if (sel_control) begin
            next_prdata = {16'h0000, timer_control};
        end else if (sel_istatus) begin
            next_prdata = {31'h00000000, irq_status};
        end else if (sel_imask) begin
            next_prdata = {31'h00000000, irq_mask};
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else if (answer) begin
            pready  <= 1'b1;
            pslverr <= ~mapped;
            prdata  <= next_prdata;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule // wkt_timer

/* File: wkt_timer_sva.sv */
// assertion checker for the wake-up timer bus port and interrupt line
`timescale 1ns/10ps
`include "wkt_defines.vh"
module wkt_timer_sva (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire mapped = paddr >= `WKT_ADDR_RELOAD && paddr <= `WKT_ADDR_IMASK && paddr[1:0] == 2'h0;
    sequence wait_s;
        psel && penable && !pready;
    endsequence
    sequence read_s(a);
        psel && penable && pready && !pwrite && paddr == a;
    endsequence
    ready_wait_a: assert property (wait_s |=> pready ##1 !pready) else $error("pready late or long");
    ready_cause_a: assert property (pready |-> $past(psel && penable)) else $error("pready without access");
    err_unmapped_a: assert property (pready && !mapped |-> pslverr && prdata == 32'h0) else $error("not refused");
    err_mapped_a: assert property (pready && mapped |-> !pslverr) else $error("mapped access refused");
    clr_zero_a: assert property (read_s(`WKT_ADDR_ICLEAR) |-> prdata == 32'h0) else $error("clear read");
    ctrl_rsvd_a: assert property (read_s(`WKT_ADDR_CONTROL) |-> prdata[31:11] == 21'h0)
        else $error("reserved control bits set");
    mask_irq_a: assert property (read_s(`WKT_ADDR_IMASK) ##0 !prdata[0] |-> !irq ##1 !irq)
        else $error("irq while masked");
    idle_irq_a: assert property (read_s(`WKT_ADDR_ISTATUS) ##0 !prdata[0] |-> !irq)
        else $error("irq without status");
endmodule // wkt_timer_sva
bind wkt_timer wkt_timer_sva i_wkt_timer_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
    .pready, .pslverr, .irq);

/* File: wkt_timer_tb_top.sv */
// self-checking bench for the wake-up timer
`timescale 1ns/10ps
`include "wkt_defines.vh"
module wkt_timer_tb_top;
    typedef struct {logic [31:0] ld, ctl, lo, hi; logic run; int cyc;} wkt_row_t;
    logic        pclk, presetn, psel, penable, pwrite, core_clk_run, lposc_clk, xtal_clk, prec_clk;
    logic [31:0] paddr, pwdata, rd, keep;
    wire  [31:0] prdata;
    wire         pready, pslverr, irq;
    int          err_count = 0, check_count = 0, cyc = 0;
    wkt_row_t    rows [12];
    logic [31:0] ra [7] = '{`WKT_ADDR_RELOAD, `WKT_ADDR_COUNT, `WKT_ADDR_CONTROL, `WKT_ADDR_ICLEAR,
                            `WKT_ADDR_ISTATUS, `WKT_ADDR_IMASK, 32'hffff0358};
    logic [31:0] rv [7] = '{32'h0, 32'hffffffff, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    wkt_timer i_wkt_timer (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
                           .pslverr, .core_clk_run, .lposc_clk, .xtal_clk, .prec_clk, .irq);
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // slow sources run far above 32 kHz so a tick costs 16 to 64 cycles, not thousands
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        {prec_clk, xtal_clk, lposc_clk} <= {cyc[5], cyc[4], cyc[3]};
        if (cyc == 90000) begin
            err_count = err_count + 1;
            stop_test;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        check_count = check_count + 1;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            err_count = err_count + 1;
            $display("BAD %0t count %h not in %h..%h", $time, got, lo, hi);
        end
    endtask
    task chk_irq(input logic exp);
        @(posedge pclk);
        chk({31'h0, irq}, {31'h0, exp});
    endtask
    task apb(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        chk({31'h0, pslverr}, {31'h0, err});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0);
    endtask
    task stop_test;
        if (err_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        {presetn, psel, penable, pwrite, core_clk_run, lposc_clk, xtal_clk, prec_clk, paddr, pwdata} = '0;
        rows = '{'{32'h3e8, 32'h0080, 32'h2a0, 32'h2a8, 1'b1, 320}, '{32'h3e8, 32'h0084, 32'h3d2, 32'h3d5, 1'b1, 320},
                 '{32'h3e8, 32'h0280, 32'h3d2, 32'h3d6, 1'b0, 320}, '{32'h3e8, 32'h0480, 32'h3dc, 32'h3df, 1'b0, 320},
                 '{32'h3e8, 32'h0680, 32'h3e1, 32'h3e4, 1'b0, 320}, '{32'h3e8, 32'h0080, 32'h3e8, 32'h3e8, 1'b0, 320},
                 '{32'h3e8, 32'h0180, 32'h528, 32'h530, 1'b1, 320}, '{32'h3e8, 32'h0090, 32'h2a0, 32'h2a8, 1'b1, 320},
                 '{32'h3e8, 32'h008f, 32'h3e7, 32'h3e7, 1'b1, 40000},
                 '{32'h173b3b62, 32'h03a8, 32'h0, 32'h0, 1'b0, 10240},
                 '{32'hff3b3b62, 32'h03b8, 32'h0, 32'h0, 1'b0, 10240},
                 '{32'h0, 32'h02a8, 32'h173b3b63, 32'h173b3b63, 1'b0, 6144}};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i]) begin
            wr(`WKT_ADDR_CONTROL, 32'h0);
            wr(`WKT_ADDR_RELOAD, rows[i].ld);
            core_clk_run <= rows[i].run;
            wr(`WKT_ADDR_CONTROL, rows[i].ctl);
            repeat (rows[i].cyc) @(posedge pclk);
            wr(`WKT_ADDR_CONTROL, 32'h0);
            apb(1'b0, `WKT_ADDR_COUNT, 32'h0, 1'b0);
            chk_rng(rd, rows[i].lo, rows[i].hi);
        end
        // the wraps above left the status set, so only the mask holds irq low
        chk_irq(1'b0);
        wr(`WKT_ADDR_IMASK, 32'h1);
        chk_irq(1'b1);
        wr(`WKT_ADDR_ICLEAR, 32'ha5);
        chk_irq(1'b0);
        wr(`WKT_ADDR_RELOAD, 32'h3);
        core_clk_run <= 1'b1;
        wr(`WKT_ADDR_CONTROL, 32'h00c0);
        repeat (20) @(posedge pclk);
        wr(`WKT_ADDR_CONTROL, 32'h0);
        apb(1'b0, `WKT_ADDR_COUNT, 32'h0, 1'b0);
        chk_rng(rd, 32'h0, 32'h3);
        chk_irq(1'b1);
        keep = rd;
        wr(`WKT_ADDR_COUNT, 32'h12345678);
        apb(1'b0, `WKT_ADDR_COUNT, 32'h0, 1'b0);
        chk(rd, keep);
        wr(`WKT_ADDR_CONTROL, 32'hfffff83f);
        apb(1'b0, `WKT_ADDR_CONTROL, 32'h0, 1'b0);
        chk(rd, 32'h3f);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (ra[i]) begin
            apb(1'b0, ra[i], 32'h0, i == 6);
            chk(rd, rv[i]);
        end
        stop_test;
    end
endmodule // wkt_timer_tb_top
